// ---- lbsgc_bus_node.sv ----
// Purpose: far-side bus node that pulls the single-wire bus low
// Assumes: open-drain wire with pull-up; device drives low via i_txd
// Notes:   the bench calls drive() just after a rising edge
`timescale 1ns/10ps
module lbsgc_bus_node (
  input  wire logic i_txd,
  output logic      o_bus
);
  logic drv_low_r;

  // wired-and: either party may hold the line low, pull-up otherwise
  assign o_bus = ~drv_low_r & i_txd;

  initial drv_low_r = 1'b0;

  task automatic drive(input logic low);
    drv_low_r <= low;
  endtask
endmodule // lbsgc_bus_node

// ---- lbsgc_edge.sv ----
// Purpose: synchronises the bus pin and reports its edges
// Assumes: pin is asynchronous to i_clk; idle bus is high
// Notes:   a change counts once stages two and three agree
`timescale 1ns/10ps
module lbsgc_edge (
  input  wire logic   i_clk,
  input  wire logic   i_rst_b,
  input  wire logic   i_pin,
  lbsgc_edge_if.src   e
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;
  logic rise_r;
  logic fall_r;

  wire agree = (s2_r == s3_r);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lvl_r  <= 1'b1;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      lvl_r  <= agree ? s3_r : lvl_r;
      rise_r <= agree & s3_r & ~lvl_r;
      fall_r <= agree & ~s3_r & lvl_r;
    end
  end

  assign e.lvl  = lvl_r;
  assign e.rise = rise_r;
  assign e.fall = fall_r;

endmodule // lbsgc_edge

// ---- lbsgc_edge_if.sv ----
// Purpose: carries the filtered bus level and its edge pulses
// Assumes: one clock domain
// Notes:   src is the edge detector, dst the control logic
`timescale 1ns/10ps
interface lbsgc_edge_if;
  logic lvl;
  logic rise;
  logic fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface // lbsgc_edge_if

// ---- lbsgc_pkg.sv ----
// Purpose: constants shared by the sync gating control block
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes:   offsets, bit positions and most reset values live here; the bench also spells offsets and status bits as literals
package lbsgc_pkg;

  localparam int AW = 5;
  localparam int TW = 16;

  localparam logic [AW-1:0] OFS_CTRL     = 5'h00;
  localparam logic [AW-1:0] OFS_CFG_B    = 5'h04;
  localparam logic [AW-1:0] OFS_STATUS   = 5'h08;
  localparam logic [AW-1:0] OFS_SYNC_TMR = 5'h0c;
  localparam logic [AW-1:0] OFS_CMP      = 5'h10;
  localparam logic [AW-1:0] OFS_BRK_TMR  = 5'h14;

  // control register bits
  localparam int CTL_W         = 11;
  localparam int CTL_MODE      = 0;
  localparam int CTL_SYNC_EN   = 1;
  localparam int CTL_CMP_EN    = 2;
  localparam int CTL_STOP_RISE = 7;
  localparam int CTL_GATE      = 8;
  localparam int CTL_BSD_WR    = 9;
  localparam int CTL_DRV_LOW   = 10;
  localparam logic [CTL_W-1:0] CTRL_RST = 11'h000;

  // second config register: edge-count field
  localparam int CFG_W      = 8;
  localparam int EDGE_LSB   = 4;
  localparam int EDGE_W     = 4;
  localparam logic [CFG_W-1:0] CFG_B_RST = 8'h00;

  // status register bits
  localparam int STS_BRK      = 0;
  localparam int STS_DONE     = 1;
  localparam int STS_BRK_RUN  = 2;
  localparam int STS_CMP      = 3;

  localparam logic [TW-1:0] CMP_RST    = 16'h0000;
  localparam logic [TW-1:0] TMR_RST    = 16'h0000;
  localparam logic [TW-1:0] BRK_MIN_DF = 16'h0400;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_DONE = 2'b11
  } lbsgc_state_e;

endpackage

// ---- lbsgc_top.sv ----
// Purpose: receive gating, break timer and sync timer stop control
// Assumes: Avalon-MM slave, one wait state per access
// Notes:   software drives the bus in bit-serial write mode
`timescale 1ns/10ps
module lbsgc_top #(
  parameter logic [15:0] BRK_MIN = lbsgc_pkg::BRK_MIN_DF
) (
  input  wire logic                     I_CLK,
  input  wire logic                     I_RST_B,
  input  wire logic [lbsgc_pkg::AW-1:0] I_ADDRESS,
  input  wire logic                     I_READ,
  input  wire logic                     I_WRITE,
  input  wire logic [31:0]              I_WRITEDATA,
  output logic      [31:0]              O_READDATA,
  output logic                          O_WAITREQUEST,
  input  wire logic                     I_BUS_RX,
  output logic                          O_UART_RXD,
  output logic                          O_BSD_TXD,
  output logic                          O_SYNC_IRQ
);

  localparam int TW = lbsgc_pkg::TW;

  function automatic logic [TW-1:0] inc(input logic [TW-1:0] v);
    inc = v + 16'h0001;
  endfunction

  lbsgc_edge_if e ();

  lbsgc_edge u_edge (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_pin   (I_BUS_RX),
    .e       (e.src)
  );

  logic [lbsgc_pkg::CTL_W-1:0] ctrl_r;
  logic [lbsgc_pkg::CFG_W-1:0] cfg_b_r;
  logic [TW-1:0]               cmp_r;
  logic [TW-1:0]               sync_tmr_r;
  logic [TW-1:0]               brk_tmr_r;
  logic                        brk_run_r;
  logic                        brk_held_r;
  logic [lbsgc_pkg::EDGE_W-1:0] edge_cnt_r;
  logic                        sts_brk_r;
  logic                        sts_cmp_r;
  logic                        ack_r;
  logic [31:0]                 rdata_r;
  logic                        rxd_r;
  logic                        txd_r;
  lbsgc_pkg::lbsgc_state_e     state_r;
  lbsgc_pkg::lbsgc_state_e     state_nxt;

  // bus slave: one wait state, then answer
  wire acc    = I_READ | I_WRITE;
  wire wr_go  = I_WRITE & ack_r;
  wire rd_go  = I_READ & ack_r;
  wire sel_ct = (I_ADDRESS == lbsgc_pkg::OFS_CTRL);
  wire sel_cf = (I_ADDRESS == lbsgc_pkg::OFS_CFG_B);
  wire sel_st = (I_ADDRESS == lbsgc_pkg::OFS_STATUS);
  wire sel_sy = (I_ADDRESS == lbsgc_pkg::OFS_SYNC_TMR);
  wire sel_cm = (I_ADDRESS == lbsgc_pkg::OFS_CMP);
  wire sel_bk = (I_ADDRESS == lbsgc_pkg::OFS_BRK_TMR);

  wire mode_bsd  = ctrl_r[lbsgc_pkg::CTL_MODE];
  wire sync_en   = ctrl_r[lbsgc_pkg::CTL_SYNC_EN];
  wire cmp_en    = ctrl_r[lbsgc_pkg::CTL_CMP_EN];
  wire stop_rise = ctrl_r[lbsgc_pkg::CTL_STOP_RISE];
  wire gate      = ctrl_r[lbsgc_pkg::CTL_GATE];
  wire [lbsgc_pkg::EDGE_W-1:0] edge_sel =
    cfg_b_r[lbsgc_pkg::EDGE_LSB +: lbsgc_pkg::EDGE_W];

  wire [31:0] sts_word = {28'h0000000, sts_cmp_r, brk_run_r,
                          (state_r == lbsgc_pkg::ST_DONE), sts_brk_r};
  wire [31:0] rd_mux =
    sel_ct ? {21'h0, ctrl_r} :
    sel_cf ? {24'h000000, cfg_b_r} :
    sel_st ? sts_word :
    sel_sy ? {16'h0000, sync_tmr_r} :
    sel_cm ? {16'h0000, cmp_r} :
    sel_bk ? {16'h0000, brk_tmr_r} : 32'h00000000;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r   <= acc & ~ack_r;
      rdata_r <= (I_READ & ~ack_r) ? rd_mux : rdata_r;
    end
  end

  assign O_WAITREQUEST = acc & ~ack_r;
  assign O_READDATA    = rdata_r;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_r  <= lbsgc_pkg::CTRL_RST;
      cfg_b_r <= lbsgc_pkg::CFG_B_RST;
      cmp_r   <= lbsgc_pkg::CMP_RST;
    end else begin
      if (wr_go & sel_ct) ctrl_r <= I_WRITEDATA[lbsgc_pkg::CTL_W-1:0];
      if (wr_go & sel_cf) cfg_b_r <= I_WRITEDATA[lbsgc_pkg::CFG_W-1:0];
      if (wr_go & sel_cm) cmp_r <= I_WRITEDATA[TW-1:0];
    end
  end

  // break timer
  wire brk_rd    = rd_go & sel_bk;
  wire brk_start = e.fall & (~brk_held_r | ~mode_bsd);
  wire brk_stop  = brk_run_r & e.rise;
  wire brk_qual  = ~mode_bsd & brk_stop & (brk_tmr_r >= BRK_MIN);

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      brk_tmr_r  <= lbsgc_pkg::TMR_RST;
      brk_run_r  <= 1'b0;
      brk_held_r <= 1'b0;
    end else begin
      if (brk_start) begin
        brk_tmr_r <= lbsgc_pkg::TMR_RST;
        brk_run_r <= 1'b1;
      end else if (brk_stop) begin
        brk_run_r <= 1'b0;
      end else if (brk_run_r) begin
        brk_tmr_r <= inc(brk_tmr_r);
      end
      brk_held_r <= brk_stop | (brk_held_r & ~brk_rd & ~brk_start);
    end
  end

  // sync field state and edge counter
  wire stop_edge = stop_rise ? e.rise : e.fall;
  wire [lbsgc_pkg::EDGE_W-1:0] edge_nxt = edge_cnt_r + 4'h1;
  wire stop_hit  = (state_r == lbsgc_pkg::ST_SYNC) & stop_edge &
                   (edge_nxt == edge_sel);

  always_comb begin
    state_nxt = state_r;
    if (mode_bsd | ~sync_en) begin
      state_nxt = lbsgc_pkg::ST_IDLE;
    end else if (brk_qual) begin
      state_nxt = lbsgc_pkg::ST_SYNC;
    end else begin
      case (state_r)
        lbsgc_pkg::ST_SYNC: begin
          if (stop_hit) state_nxt = lbsgc_pkg::ST_DONE;
        end
        default: state_nxt = state_r;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_r    <= lbsgc_pkg::ST_IDLE;
      edge_cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      if (brk_qual) edge_cnt_r <= 4'h0;
      else if ((state_r == lbsgc_pkg::ST_SYNC) & stop_edge)
        edge_cnt_r <= edge_nxt;
    end
  end

  // sync bit timer and compare
  wire sync_clr = mode_bsd ? e.fall : brk_qual;
  wire sync_cnt = mode_bsd ? ~e.lvl : (state_r == lbsgc_pkg::ST_SYNC);
  wire cmp_set  = cmp_en & sync_cnt & ~sync_clr &
                  (inc(sync_tmr_r) == cmp_r);
  wire brk_set  = mode_bsd & gate & e.rise;
  wire sts_wr   = wr_go & sel_st;
  wire brk_clr  = sts_wr & I_WRITEDATA[lbsgc_pkg::STS_BRK];
  wire cmp_clr  = sts_wr & I_WRITEDATA[lbsgc_pkg::STS_CMP];

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sync_tmr_r <= lbsgc_pkg::TMR_RST;
      sts_brk_r  <= 1'b0;
      sts_cmp_r  <= 1'b0;
    end else begin
      if (sync_clr) sync_tmr_r <= lbsgc_pkg::TMR_RST;
      else if (sync_cnt) sync_tmr_r <= inc(sync_tmr_r);
      sts_brk_r <= brk_set | (sts_brk_r & ~brk_clr);
      sts_cmp_r <= cmp_set | (sts_cmp_r & ~cmp_clr);
    end
  end

  // receive gating and bit-serial transmit
  wire gate_act = ~mode_bsd & sync_en & gate &
                  (state_r != lbsgc_pkg::ST_DONE);

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rxd_r <= 1'b1;
      txd_r <= 1'b1;
    end else begin
      rxd_r <= gate_act | e.lvl;
      txd_r <= ~(mode_bsd & ctrl_r[lbsgc_pkg::CTL_BSD_WR] &
                 ctrl_r[lbsgc_pkg::CTL_DRV_LOW]);
    end
  end

  assign O_UART_RXD = rxd_r;
  assign O_BSD_TXD  = txd_r;
  assign O_SYNC_IRQ = sts_brk_r | sts_cmp_r;

  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  gate_hold_a: assert property (gate_act |=> O_UART_RXD)
    else $error("receive line not held high while gated");
  rx_pass_a: assert property (~gate_act |=> O_UART_RXD == $past(e.lvl))
    else $error("receive line not passed through");
  brk_block_a: assert property (
    mode_bsd & ~gate & e.rise & ~sts_brk_r |=> ~sts_brk_r)
    else $error("break flag set while disabled");
  brk_raise_a: assert property (
    mode_bsd & gate & e.rise |=> sts_brk_r & O_SYNC_IRQ)
    else $error("break interrupt missing on release");
  brk_stop_a: assert property (
    brk_run_r & e.rise |=> ~brk_run_r ##1 $stable(brk_tmr_r))
    else $error("break timer not stopped on rise");
  cmp_flag_a: assert property (
    cmp_set |=> sts_cmp_r & O_SYNC_IRQ & sync_tmr_r == cmp_r)
    else $error("compare flag not raised on match");
  cmp_sts_a: assert property (
    rd_go & sel_st & $past(sts_cmp_r) |-> O_READDATA[lbsgc_pkg::STS_CMP])
    else $error("compare flag not visible in status");
  stop_rise_a: assert property (
    state_r == lbsgc_pkg::ST_SYNC & stop_rise & e.rise & sync_en &
    ~mode_bsd & ~brk_qual & edge_nxt == edge_sel
    |=> state_r == lbsgc_pkg::ST_DONE)
    else $error("sync timer not stopped on counted rise");
  stop_fall_a: assert property (
    state_r == lbsgc_pkg::ST_SYNC & ~stop_rise & e.rise
    |=> state_r != lbsgc_pkg::ST_DONE || $past(brk_qual) == 1'b0
        && $past(state_r) == lbsgc_pkg::ST_DONE)
    else $error("sync timer stopped on wrong edge");
  mode_sel_a: assert property (mode_bsd |=> state_r == lbsgc_pkg::ST_IDLE)
    else $error("LIN sync logic active in bit-serial mode");
  brk_start_a: assert property (
    brk_start |=> brk_run_r & brk_tmr_r == 16'h0000)
    else $error("break timer not started on fall");
  brk_hold_a: assert property (
    brk_held_r & mode_bsd & ~brk_rd |=> $stable(brk_tmr_r))
    else $error("held break count changed before read");

  sync_done_c: cover property (state_r == lbsgc_pkg::ST_SYNC ##1
                               state_r == lbsgc_pkg::ST_DONE);
  cmp_hit_c: cover property (cmp_set);
  brk_irq_c: cover property (brk_set);
  brk_read_c: cover property (brk_held_r ##1 brk_rd);

endmodule // lbsgc_top

// ---- lbsgc_top_test.sv ----
// Purpose: self-checking bench for the sync gating control block
// Assumes: one wait state per register access, short break minimum
// Notes:   random widths, counts and compare values from a fixed seed
`timescale 1ns/10ps
module lbsgc_top_test;
  localparam int BRK = 16;
  logic        clk      = 1'b0;
  logic        rst_b;
  logic [4:0]  addr;
  logic        rd_en;
  logic        wr_en;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wait_req;
  logic        bus;
  logic        uart_rxd;
  logic        txd;
  logic        irq;
  logic [31:0] v;
  logic [31:0] t;
  logic [4:0]  ofs [7] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18};
  int          mismatches = 0;
  int          checked    = 0;
  int          cyc        = 0;
  int          w;
  int          c;

  always #2 clk = ~clk;

  lbsgc_top #(.BRK_MIN(16'h0010)) lbsgc_top_inst (
    .I_CLK         (clk),
    .I_RST_B       (rst_b),
    .I_ADDRESS     (addr),
    .I_READ        (rd_en),
    .I_WRITE       (wr_en),
    .I_WRITEDATA   (wdata),
    .O_READDATA    (rdata),
    .O_WAITREQUEST (wait_req),
    .I_BUS_RX      (bus),
    .O_UART_RXD    (uart_rxd),
    .O_BSD_TXD     (txd),
    .O_SYNC_IRQ    (irq)
  );

  lbsgc_bus_node lbsgc_bus_node_inst (
    .i_txd (txd),
    .o_bus (bus)
  );

  task automatic summarize;
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus cycle; held until waitrequest low is seen at a rising edge
  task automatic access(input logic [4:0] a, input logic wn,
                        input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    rd_en <= ~wn;
    wr_en <= wn;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    v = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    access(a, 1'b1, d);
  endtask

  task automatic rd(input logic [4:0] a);
    access(a, 1'b0, 32'h0);
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [31:0] ctl(input logic m, s, cm, r, g, wm, dl);
    ctl = 32'h0;
    ctl[lbsgc_pkg::CTL_MODE]      = m;
    ctl[lbsgc_pkg::CTL_SYNC_EN]   = s;
    ctl[lbsgc_pkg::CTL_CMP_EN]    = cm;
    ctl[lbsgc_pkg::CTL_STOP_RISE] = r;
    ctl[lbsgc_pkg::CTL_GATE]      = g;
    ctl[lbsgc_pkg::CTL_BSD_WR]    = wm;
    ctl[lbsgc_pkg::CTL_DRV_LOW]   = dl;
  endfunction

  function automatic logic [31:0] near(input logic [31:0] x, input int e);
    near = {31'h0, (x >= e - 2) && (x <= e + 2)};
  endfunction

  // break, then n+1 pulses; the nth selected edge ends the sync phase, the last pulse passes through
  task automatic lin_sync(input logic r, input logic g, input int n);
    wr(lbsgc_pkg::OFS_CTRL, 32'h0); // sync off re-arms the gate
    wr(lbsgc_pkg::OFS_CTRL, ctl(1'b0, 1'b1, 1'b0, r, g, 1'b0, 1'b0));
    wr(lbsgc_pkg::OFS_CFG_B, 32'(n) << 4);
    lbsgc_bus_node_inst.drive(1'b1);
    wait_clk(BRK + 10);
    chk({31'h0, uart_rxd}, {31'h0, g});
    lbsgc_bus_node_inst.drive(1'b0);
    wait_clk(10);
    for (int k = 1; k <= n; k++) begin
      lbsgc_bus_node_inst.drive(1'b1);
      wait_clk(8);
      chk({31'h0, uart_rxd}, {31'h0, g & (r | (k < n))});
      lbsgc_bus_node_inst.drive(1'b0);
      wait_clk(8);
      rd(lbsgc_pkg::OFS_STATUS);
      chk({31'h0, v[1]}, {31'h0, k == n});
    end
    lbsgc_bus_node_inst.drive(1'b1);
    wait_clk(8);
    chk({31'h0, uart_rxd}, 32'h0);
    lbsgc_bus_node_inst.drive(1'b0);
    wait_clk(8);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      summarize;
    end
  end

  initial begin
    rst_b <= 1'b0;
    addr  <= 5'h00;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    wdata <= 32'h0;
    void'($urandom(32'h65b773f8));
    wait_clk(20);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({29'h0, uart_rxd, txd, irq}, 32'h6);
    // reset values, and an unmapped place that ignores writes
    wr(5'h18, $urandom);
    foreach (ofs[i]) begin
      rd(ofs[i]);
      chk(v, 32'h0);
    end
    c = 30 + $urandom_range(30);
    wr(lbsgc_pkg::OFS_CMP, 32'(c));
    rd(lbsgc_pkg::OFS_CMP);
    chk(v, 32'(c));
    for (int m = 0; m < 4; m++)
      lin_sync(m[0], m[1], 1 + $urandom_range(3));
    // bit-serial write: device pulls low itself, then releases
    for (int g = 0; g < 2; g++) begin
      rd(lbsgc_pkg::OFS_BRK_TMR); // releases a held count
      wr(lbsgc_pkg::OFS_CTRL, ctl(1, 0, 0, 0, g[0], 1, 1));
      wait_clk(30);
      wr(lbsgc_pkg::OFS_CTRL, ctl(1, 0, 0, 0, g[0], 1, 0));
      wait_clk(10);
      rd(lbsgc_pkg::OFS_STATUS);
      chk({31'h0, v[0]}, 32'(g));
      chk({31'h0, irq}, 32'(g));
      rd(lbsgc_pkg::OFS_BRK_TMR);
      chk(near(v, 33), 32'h1);
      wr(lbsgc_pkg::OFS_STATUS, 32'h1);
      rd(lbsgc_pkg::OFS_STATUS);
      chk({31'h0, v[0]}, 32'h0);
    end
    // bit-serial read: far node sends a low pulse of random width
    w = 20 + $urandom_range(40);
    wr(lbsgc_pkg::OFS_CTRL, ctl(1, 0, 0, 0, 0, 0, 0));
    lbsgc_bus_node_inst.drive(1'b1);
    wait_clk(10);
    rd(lbsgc_pkg::OFS_STATUS);
    chk({31'h0, v[2]}, 32'h1);
    wait_clk(w - 13);
    lbsgc_bus_node_inst.drive(1'b0);
    wait_clk(10);
    rd(lbsgc_pkg::OFS_STATUS);
    chk({31'h0, v[2]}, 32'h0);
    // a second pulse must not restart the held count
    lbsgc_bus_node_inst.drive(1'b1);
    wait_clk(8);
    lbsgc_bus_node_inst.drive(1'b0);
    wait_clk(8);
    rd(lbsgc_pkg::OFS_BRK_TMR);
    t = v;
    chk(near(v, w), 32'h1);
    wait_clk(20);
    rd(lbsgc_pkg::OFS_BRK_TMR);
    chk(v, t);
    // compare match while the bus is held low
    wr(lbsgc_pkg::OFS_CTRL, ctl(1, 0, 1, 0, 0, 0, 0));
    lbsgc_bus_node_inst.drive(1'b1);
    wait_clk(c / 2);
    rd(lbsgc_pkg::OFS_STATUS);
    chk({31'h0, v[3]}, 32'h0);
    wait_clk(c);
    rd(lbsgc_pkg::OFS_STATUS);
    chk({31'h0, v[3]}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    lbsgc_bus_node_inst.drive(1'b0);
    wr(lbsgc_pkg::OFS_STATUS, 32'h8);
    rd(lbsgc_pkg::OFS_STATUS);
    chk({31'h0, v[3]}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    summarize;
  end
endmodule // lbsgc_top_test
